// ===== src/fwdr_pkg.sv
package fwdr_pkg;

   // Register offsets on the serial control bus
   localparam logic [7:0] ADDR_THERMAL = 8'h12;
   localparam logic [7:0] ADDR_WARN = 8'h13;
   localparam logic [7:0] ADDR_MASK = 8'h14;
   localparam logic [7:0] ADDR_ACA = 8'h15;
   localparam logic [7:0] ADDR_ACB = 8'h16;
   localparam logic [7:0] ADDR_IMP_ONE = 8'h17;
   localparam logic [7:0] ADDR_IMP_TWO = 8'h18;
   localparam logic [7:0] ADDR_MISC = 8'h21;

   // Reset values
   localparam logic [7:0] RST_THERMAL = 8'h00;
   localparam logic [7:0] RST_WARN = 8'h20;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_ACA = 8'h00;
   localparam logic [7:0] RST_ACB = 8'h00;
   localparam logic [7:0] RST_MISC = 8'h00;
   localparam logic [7:0] RST_IMP = 8'h00;

   // Thermal shutdown status fields
   localparam int THM_GLOBAL = 4;
   localparam int THM_CH_ONE = 3;
   localparam int THM_CH_TWO = 2;

   // Warning status fields
   localparam int WRN_POR = 5;
   localparam int WRN_GLOBAL = 4;
   localparam int WRN_CH_ONE = 3;
   localparam int WRN_CH_TWO = 2;

   // Pin report mask fields
   localparam int MSK_OC = 7;
   localparam int MSK_THERMAL_SHUTDOWN_FLAG = 6;
   localparam int MSK_UV = 5;
   localparam int MSK_OV = 4;
   localparam int MSK_DC = 3;
   localparam int MSK_CLIP = 1;
   localparam int MSK_OTW = 0;

   // Impedance test control fields
   localparam int ACA_GAIN_ONE = 7;
   localparam int ACA_GAIN_TWO = 6;
   localparam int ACA_ON_ONE = 3;
   localparam int ACA_ON_TWO = 2;
   localparam int ACB_LOOP = 7;
   localparam int ACB_LONG = 4;
   localparam int ACB_CUR_HI = 3;
   localparam int ACB_CUR_LO = 2;

   // Miscellaneous control fields
   localparam int MISC_CLEAR = 7;
   localparam int MISC_AUTOREC = 3;

   // Drive current codes
   localparam logic [1:0] CUR_10MA = 2'b00;
   localparam logic [1:0] CUR_19MA = 2'b01;

   // Measurement lengths in tone cycles
   localparam logic [6:0] RUN_SHORT = 7'd32;
   localparam logic [6:0] RUN_LONG = 7'd64;

   // System clock cycles per tone cycle
   localparam logic [15:0] TONE_DIV = 16'd250;

   // Bus address, arbitrary value
   localparam logic [6:0] BUS_ADDR = 7'h2a;

   typedef enum logic [3:0] {
      I2C_IDLE = 4'h0,
      I2C_ADDR = 4'h1,
      I2C_ADDR_ACK = 4'h2,
      I2C_REG = 4'h3,
      I2C_REG_ACK = 4'h4,
      I2C_WDATA = 4'h5,
      I2C_WACK = 4'h6,
      I2C_RDATA = 4'h7,
      I2C_RACK = 4'h8
   } fwdr_i2c_t;

endpackage

// ===== src/fwdr_pin_report.sv
`timescale 1ns/1ps
module fwdr_pin_report (
   input wire logic clk,
   input wire logic rstN,
   input wire logic [7:0] mask,
   input wire logic ocFault,
   input wire logic tsdFault,
   input wire logic uvFault,
   input wire logic ovFault,
   input wire logic dcFault,
   input wire logic clipDetect,
   input wire logic twFault,
   output logic faultN,
   output logic warnN
);

   wire faultAny;
   wire warnAny;

   // Unmasked fault sources
   assign faultAny = (ocFault & ~mask[fwdr_pkg::MSK_OC])
      | (tsdFault & ~mask[fwdr_pkg::MSK_THERMAL_SHUTDOWN_FLAG])
      | (uvFault & ~mask[fwdr_pkg::MSK_UV])
      | (ovFault & ~mask[fwdr_pkg::MSK_OV])
      | (dcFault & ~mask[fwdr_pkg::MSK_DC]);

   // Unmasked warning sources
   assign warnAny = (clipDetect & ~mask[fwdr_pkg::MSK_CLIP])
      | (twFault & ~mask[fwdr_pkg::MSK_OTW]);

   // Active-low pins, registered
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         faultN <= 1'b1;
         warnN <= 1'b1;
      end else begin
         faultN <= ~faultAny;
         warnN <= ~warnAny;
      end
   end

endmodule // fwdr_pin_report

// ===== src/fwdr_ac_test.sv
`timescale 1ns/1ps
module fwdr_ac_test #(
   parameter int SAMPLE_W = 8
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic tick,
   input wire logic testOn,
   input wire logic gainFour,
   input wire logic longRun,
   input wire logic [SAMPLE_W-1:0] sample,
   output logic [7:0] impedance,
   output logic busy
);

   if (SAMPLE_W != 8) begin : gWidthCheck
      $error("fwdr_ac_test serves 8-bit samples only");
   end

   logic onPrev;
   logic [6:0] count;
   logic [13:0] acc;
   wire startRun;
   wire [6:0] runLen;
   wire lastTick;
   wire [13:0] sumNow;
   wire [7:0] avg;
   wire [7:0] scaled;

   // Run length, average and gain scaling
   assign startRun = testOn & ~onPrev;
   assign runLen = longRun ? fwdr_pkg::RUN_LONG : fwdr_pkg::RUN_SHORT;
   assign lastTick = tick & (count >= runLen - 7'd1); // Length change mid-run cannot overrun
   assign sumNow = acc + {6'h00, sample};
   assign avg = longRun ? sumNow[13:6] : sumNow[12:5];
   assign scaled = gainFour ? {2'b00, avg[7:2]} : avg;

   // Edge of enable
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         onPrev <= 1'b0;
      end else begin
         onPrev <= testOn;
      end
   end

   // Sequencer, runs only while enabled
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         busy <= 1'b0;
         count <= 7'd0;
         acc <= 14'h0000;
      end else if (!testOn) begin
         busy <= 1'b0;
      end else if (startRun) begin
         busy <= 1'b1;
         count <= 7'd0;
         acc <= 14'h0000;
      end else if (busy && tick) begin
         busy <= ~lastTick;
         count <= count + 7'd1;
         acc <= sumNow;
      end
   end

   // Result code, 0.2496 ohm per step
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         impedance <= fwdr_pkg::RST_IMP;
      end else if (busy && testOn && lastTick) begin
         impedance <= scaled;
      end
   end

endmodule // fwdr_ac_test

// ===== src/fault_warning_diag_regs.sv
`timescale 1ns/1ps
// Contract
// - Thermal bit 4: global overtemperature shutdown.
// - Thermal bits 3, 2: per-channel shutdown.
// - Warning bit 5: logic-supply power-on reset seen.
// - Warning bit 4: global overtemperature warning.
// - Warning bits 3, 2: per-channel overtemperature warnings.
// - Mask bit 7 keeps overcurrent off the fault pin.
// - Mask bit 6 keeps thermal shutdown off the fault pin.
// - Mask bit 5 keeps undervoltage off the fault pin.
// - Mask bit 4 keeps overvoltage off the fault pin.
// - Mask bit 3 keeps output offset off the fault pin.
// - Mask bit 1 keeps clipping off the warning pin.
// - Mask bit 0 keeps overtemperature warnings off the warning pin.
// - Test gain bits 7, 6 per channel: 0 gives 1, 1 gives 4.
// - Impedance test runs on a channel only while its enable bit is 1.
// - Control B bit 7 set puts the impedance test into loopback.
// - Control B bit 4 selects 32 or 64 cycles.
// - Control B bits 3-2 select 10 mA or 19 mA; codes 10, 11 reserved.
// - Writing 1 to misc bit 7 clears latched fault indications.
// - Per-channel 8-bit impedance code, 0.2496 ohm per step.
module fault_warning_diag_regs #(
   parameter logic [6:0] BUS_ADDR = fwdr_pkg::BUS_ADDR,
   parameter logic [15:0] TONE_DIV = fwdr_pkg::TONE_DIV
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic thermalShutdownFlag,
   input wire logic chOneThermalShutdown,
   input wire logic chTwoThermalShutdown,
   input wire logic thermalWarningFlag,
   input wire logic chOneThermalWarning,
   input wire logic chTwoThermalWarning,
   input wire logic ocFault,
   input wire logic uvFault,
   input wire logic ovFault,
   input wire logic dcFault,
   input wire logic clipDetect,
   input wire logic [7:0] sampleChOne,
   input wire logic [7:0] sampleChTwo,
   output logic faultN,
   output logic warnN,
   output logic [1:0] testDriveOn,
   output logic [1:0] testGainFour,
   output logic impedanceTestReturnPath,
   output logic [1:0] toneTestDriveLevel,
   output logic [1:0] testBusy
);

   if (TONE_DIV < 16'd2) begin : gDivCheck
      $error("TONE_DIV must be at least 2");
   end

   logic rstMeta;
   logic rstN;
   logic sclQ;
   logic sdaQ;
   fwdr_pkg::fwdr_i2c_t state;
   fwdr_pkg::fwdr_i2c_t next_state;
   logic [3:0] bitCnt;
   logic [3:0] next_bitCnt;
   logic [7:0] shiftReg;
   logic [7:0] next_shiftReg;
   logic [7:0] regPtr;
   logic [7:0] next_regPtr;
   logic readMode;
   logic next_readMode;
   logic wrStb;
   logic [7:0] maskReg;
   logic [7:0] acCtrlA;
   logic [7:0] acCtrlB;
   logic [7:0] miscReg;
   logic [2:0] tsdLatch;
   logic [2:0] next_tsdLatch;
   logic porFlag;
   logic [2:0] twLive;
   logic [15:0] divCnt;
   logic toneTick;
   logic [7:0] impOne;
   logic [7:0] impTwo;
   wire [7:0] rdData;
   wire [7:0] thermalReg;
   wire [7:0] warnReg;
   wire [2:0] tsdIn;
   wire sclRise;
   wire sclFall;
   wire startCond;
   wire stopCond;
   wire byteDone;
   wire wrMask;
   wire wrAcA;
   wire wrAcB;
   wire wrMisc;
   wire clearPulse;
   wire autoRecover;
   wire curReserved;
   wire [1:0] curKeep;
   wire [7:0] acBNext;

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   // Previous bus levels for edge detection
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         sclQ <= 1'b1;
         sdaQ <= 1'b1;
      end else begin
         sclQ <= scl;
         sdaQ <= sdaIn;
      end
   end

   // Bus events
   assign sclRise = scl & ~sclQ;
   assign sclFall = ~scl & sclQ;
   assign startCond = scl & sclQ & sdaQ & ~sdaIn;
   assign stopCond = scl & sclQ & ~sdaQ & sdaIn;
   assign byteDone = sclFall & (bitCnt == 4'd8);

   // Bus target sequencing
   always_comb begin
      next_state = state;
      next_bitCnt = bitCnt;
      next_shiftReg = shiftReg;
      next_regPtr = regPtr;
      next_readMode = readMode;
      wrStb = 1'b0;
      if (stopCond) begin
         next_state = fwdr_pkg::I2C_IDLE;
      end else if (startCond) begin
         next_state = fwdr_pkg::I2C_ADDR;
         next_bitCnt = 4'd0;
      end else begin
         unique case (state)
            fwdr_pkg::I2C_IDLE: begin
               next_bitCnt = 4'd0;
            end
            fwdr_pkg::I2C_ADDR, fwdr_pkg::I2C_REG, fwdr_pkg::I2C_WDATA: begin
               if (sclRise) begin
                  next_shiftReg = {shiftReg[6:0], sdaIn};
                  next_bitCnt = bitCnt + 4'd1;
               end else if (byteDone) begin
                  next_bitCnt = 4'd0;
                  if (state == fwdr_pkg::I2C_ADDR) begin
                     next_readMode = shiftReg[0];
                     next_state = (shiftReg[7:1] == BUS_ADDR) ?
                        fwdr_pkg::I2C_ADDR_ACK : fwdr_pkg::I2C_IDLE;
                  end else if (state == fwdr_pkg::I2C_REG) begin
                     next_regPtr = shiftReg;
                     next_state = fwdr_pkg::I2C_REG_ACK;
                  end else begin
                     wrStb = 1'b1;
                     next_regPtr = regPtr + 8'd1;
                     next_state = fwdr_pkg::I2C_WACK;
                  end
               end
            end
            fwdr_pkg::I2C_ADDR_ACK: begin
               if (sclFall && readMode) begin
                  next_shiftReg = rdData;
                  next_regPtr = regPtr + 8'd1;
                  next_state = fwdr_pkg::I2C_RDATA;
               end else if (sclFall) begin
                  next_state = fwdr_pkg::I2C_REG;
               end
            end
            fwdr_pkg::I2C_REG_ACK, fwdr_pkg::I2C_WACK: begin
               if (sclFall) begin
                  next_state = fwdr_pkg::I2C_WDATA;
               end
            end
            fwdr_pkg::I2C_RDATA: begin
               if (sclRise) begin
                  next_bitCnt = bitCnt + 4'd1;
               end else if (byteDone) begin
                  next_bitCnt = 4'd0;
                  next_state = fwdr_pkg::I2C_RACK;
               end else if (sclFall) begin
                  next_shiftReg = {shiftReg[6:0], 1'b0};
               end
            end
            fwdr_pkg::I2C_RACK: begin
               if (sclRise && sdaIn) begin
                  next_state = fwdr_pkg::I2C_IDLE;
               end else if (sclFall) begin
                  next_shiftReg = rdData;
                  next_regPtr = regPtr + 8'd1;
                  next_state = fwdr_pkg::I2C_RDATA;
               end
            end
            default: begin
               next_state = fwdr_pkg::I2C_IDLE;
            end
         endcase
      end
   end

   // Bus target state
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         state <= fwdr_pkg::I2C_IDLE;
         bitCnt <= 4'd0;
         shiftReg <= 8'h00;
         regPtr <= 8'h00;
         readMode <= 1'b0;
      end else begin
         state <= next_state;
         bitCnt <= next_bitCnt;
         shiftReg <= next_shiftReg;
         regPtr <= next_regPtr;
         readMode <= next_readMode;
      end
   end

   // Open drain: low for ack and zero read bits
   assign sdaOut = 1'b0;
   assign sdaOe = (state == fwdr_pkg::I2C_ADDR_ACK) | (state == fwdr_pkg::I2C_REG_ACK)
      | (state == fwdr_pkg::I2C_WACK) | ((state == fwdr_pkg::I2C_RDATA) & ~shiftReg[7]);

   // Write decode
   assign wrMask = wrStb & (regPtr == fwdr_pkg::ADDR_MASK);
   assign wrAcA = wrStb & (regPtr == fwdr_pkg::ADDR_ACA);
   assign wrAcB = wrStb & (regPtr == fwdr_pkg::ADDR_ACB);
   assign wrMisc = wrStb & (regPtr == fwdr_pkg::ADDR_MISC);
   assign clearPulse = wrMisc & shiftReg[fwdr_pkg::MISC_CLEAR];
   assign autoRecover = miscReg[fwdr_pkg::MISC_AUTOREC];

   // Reserved current codes keep old selection
   assign curReserved = shiftReg[fwdr_pkg::ACB_CUR_HI];
   assign curKeep = curReserved ? acCtrlB[fwdr_pkg::ACB_CUR_HI:fwdr_pkg::ACB_CUR_LO]
      : shiftReg[fwdr_pkg::ACB_CUR_HI:fwdr_pkg::ACB_CUR_LO];
   assign acBNext = {shiftReg[7:4], curKeep, shiftReg[1:0]};

   // Writable registers; clear bit reads 0
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         maskReg <= fwdr_pkg::RST_MASK;
         acCtrlA <= fwdr_pkg::RST_ACA;
         acCtrlB <= fwdr_pkg::RST_ACB;
         miscReg <= fwdr_pkg::RST_MISC;
      end else begin
         if (wrMask) maskReg <= shiftReg;
         if (wrAcA) acCtrlA <= shiftReg;
         if (wrAcB) acCtrlB <= acBNext;
         if (wrMisc) miscReg <= {1'b0, shiftReg[6:0]};
      end
   end

   // Shutdown flags latch unless auto recovery; set beats clear
   assign tsdIn = {thermalShutdownFlag, chOneThermalShutdown, chTwoThermalShutdown};
   always_comb begin
      next_tsdLatch = autoRecover ? tsdIn : ((tsdLatch & {3{~clearPulse}}) | tsdIn);
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         tsdLatch <= 3'b000;
         porFlag <= 1'b1;
         twLive <= 3'b000;
      end else begin
         tsdLatch <= next_tsdLatch;
         if (clearPulse) porFlag <= 1'b0;
         twLive <= {thermalWarningFlag, chOneThermalWarning, chTwoThermalWarning};
      end
   end

   // Status images
   assign thermalReg = {3'b000, tsdLatch[2], tsdLatch[1], tsdLatch[0], 2'b00};
   assign warnReg = {2'b00, porFlag, twLive[2], twLive[1], twLive[0], 2'b00};

   // Read mux, unmapped offsets read 0
   assign rdData = (regPtr == fwdr_pkg::ADDR_THERMAL) ? thermalReg
      : (regPtr == fwdr_pkg::ADDR_WARN) ? warnReg
      : (regPtr == fwdr_pkg::ADDR_MASK) ? maskReg
      : (regPtr == fwdr_pkg::ADDR_ACA) ? acCtrlA
      : (regPtr == fwdr_pkg::ADDR_ACB) ? acCtrlB
      : (regPtr == fwdr_pkg::ADDR_IMP_ONE) ? impOne
      : (regPtr == fwdr_pkg::ADDR_IMP_TWO) ? impTwo
      : (regPtr == fwdr_pkg::ADDR_MISC) ? miscReg
      : 8'h00;

   // Tone cycle enable
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         divCnt <= 16'h0000;
         toneTick <= 1'b0;
      end else begin
         toneTick <= (divCnt == TONE_DIV - 16'd1);
         divCnt <= (divCnt == TONE_DIV - 16'd1) ? 16'h0000 : divCnt + 16'd1;
      end
   end

   // Test controls to the front end
   assign testDriveOn = {acCtrlA[fwdr_pkg::ACA_ON_TWO], acCtrlA[fwdr_pkg::ACA_ON_ONE]};
   assign testGainFour = {acCtrlA[fwdr_pkg::ACA_GAIN_TWO], acCtrlA[fwdr_pkg::ACA_GAIN_ONE]};
   assign impedanceTestReturnPath = acCtrlB[fwdr_pkg::ACB_LOOP];
   assign toneTestDriveLevel = acCtrlB[fwdr_pkg::ACB_CUR_HI:fwdr_pkg::ACB_CUR_LO];

   // Impedance measurement, channel one
   fwdr_ac_test #(
      .SAMPLE_W(8)
   ) uTestOne (
      .clk(sys_clk),
      .rstN(rstN),
      .tick(toneTick),
      .testOn(testDriveOn[0]),
      .gainFour(testGainFour[0]),
      .longRun(acCtrlB[fwdr_pkg::ACB_LONG]),
      .sample(sampleChOne),
      .impedance(impOne),
      .busy(testBusy[0])
   );

   // Impedance measurement, channel two
   fwdr_ac_test #(
      .SAMPLE_W(8)
   ) uTestTwo (
      .clk(sys_clk),
      .rstN(rstN),
      .tick(toneTick),
      .testOn(testDriveOn[1]),
      .gainFour(testGainFour[1]),
      .longRun(acCtrlB[fwdr_pkg::ACB_LONG]),
      .sample(sampleChTwo),
      .impedance(impTwo),
      .busy(testBusy[1])
   );

   // Fault and warning pins
   fwdr_pin_report uPins (
      .clk(sys_clk),
      .rstN(rstN),
      .mask(maskReg),
      .ocFault(ocFault),
      .tsdFault(|tsdLatch),
      .uvFault(uvFault),
      .ovFault(ovFault),
      .dcFault(dcFault),
      .clipDetect(clipDetect),
      .twFault(|twLive),
      .faultN(faultN),
      .warnN(warnN)
   );

endmodule // fault_warning_diag_regs

// ===== bench/fwdr_host_model.sv
`timescale 1ns/1ps
module fwdr_host_model (
   input wire logic clk,
   input wire logic sdaOe,
   output logic scl,
   output logic sdaIn
);
   int ph = 4;
   logic hostLow = 1'b0;
   // Pulled-up wire, either side pulls low
   assign sdaIn = ~(hostLow | sdaOe);
   initial scl = 1'b1;
   task automatic hold();
      repeat (ph) @(posedge clk);
   endtask
   // Data moves only while the bus clock is low
   task automatic put_bit(input logic b, output logic got);
      hostLow <= ~b;
      hold();
      scl <= 1'b1;
      hold();
      got = sdaIn;
      scl <= 1'b0;
      hold();
   endtask
   task automatic start_cond();
      hostLow <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
      hostLow <= 1'b1;
      hold();
      scl <= 1'b0;
      hold();
   endtask
   task automatic stop_cond();
      hostLow <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      hostLow <= 1'b0;
      hold();
   endtask
   // Eight bits out or in, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], q[i]);
      end
      put_bit(last, ack);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
      logic [7:0] q;
      logic n0, n1, n2;
      start_cond();
      xfer({fwdr_pkg::BUS_ADDR, 1'b0}, 1'b1, q, n0);
      xfer(a, 1'b1, q, n1);
      xfer(d, 1'b1, q, n2);
      stop_cond();
      nak = n0 | n1 | n2;
   endtask
   // Pointer, repeated start, one byte, nack
   task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic nak);
      logic [7:0] u;
      logic n0, n1, n2, n3;
      start_cond();
      xfer({fwdr_pkg::BUS_ADDR, 1'b0}, 1'b1, u, n0);
      xfer(a, 1'b1, u, n1);
      start_cond();
      xfer({fwdr_pkg::BUS_ADDR, 1'b1}, 1'b1, u, n2);
      xfer(8'hff, 1'b1, q, n3);
      stop_cond();
      nak = n0 | n1 | n2;
   endtask
endmodule // fwdr_host_model

// ===== bench/fwdr_checker_props.sv
`timescale 1ns/1ps
module fwdr_checker #(
   parameter logic [15:0] TONE_DIV = 16'd250
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic scl,
   input wire logic thermalShutdownFlag,
   input wire logic chOneThermalShutdown,
   input wire logic chTwoThermalShutdown,
   input wire logic thermalWarningFlag,
   input wire logic chOneThermalWarning,
   input wire logic chTwoThermalWarning,
   input wire logic ocFault,
   input wire logic uvFault,
   input wire logic ovFault,
   input wire logic dcFault,
   input wire logic clipDetect,
   input wire logic faultN,
   input wire logic warnN,
   input wire logic [1:0] testDriveOn,
   input wire logic [1:0] testGainFour,
   input wire logic impedanceTestReturnPath,
   input wire logic [1:0] toneTestDriveLevel,
   input wire logic [1:0] testBusy
);
   localparam int MIN_RUN = 30 * TONE_DIV;
   localparam int MAX_RUN = 64 * TONE_DIV + 8;
   logic [31:0] runLen;
   logic anyFault;
   logic anyWarn;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Causes per pin
   assign anyFault = ocFault | uvFault | ovFault | dcFault | thermalShutdownFlag
                     | chOneThermalShutdown | chTwoThermalShutdown;
   assign anyWarn = thermalWarningFlag | chOneThermalWarning | chTwoThermalWarning;
   // Channel one run length
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         runLen <= 32'h0;
      end else begin
         runLen <= testBusy[0] ? runLen + 32'h1 : 32'h0;
      end
   end
   a_fault_has_cause: assert property (
      $fell(faultN) |-> $past(anyFault) || $past(anyFault, 2))
      else $error("fault pin without cause");
   a_warn_has_cause: assert property (
      $fell(warnN) |-> $past(clipDetect) || $past(anyWarn) || $past(anyWarn, 2))
      else $error("warn pin without cause");
   a_run_needs_enable: assert property (
      $rose(testBusy[0]) |-> $past(testDriveOn[0]))
      else $error("run while disabled");
   a_run_aborts: assert property (
      (testBusy & ~testDriveOn & ~$past(testDriveOn)) == 2'b00)
      else $error("run after disable");
   a_run_min_len: assert property (
      $fell(testBusy[0]) && testDriveOn[0] && $past(testDriveOn[0]) |-> runLen >= MIN_RUN)
      else $error("run too short");
   a_run_max_len: assert property (runLen <= MAX_RUN)
      else $error("run too long");
   a_current_legal: assert property (!toneTestDriveLevel[1])
      else $error("reserved current");
   a_ctrl_on_write: assert property (
      $changed({testDriveOn, testGainFour, impedanceTestReturnPath, toneTestDriveLevel})
      |-> !scl)
      else $error("controls changed off write");
   c_run_done: cover property ($fell(testBusy[0]));
   c_fault_pin: cover property ($fell(faultN));
   c_warn_pin: cover property ($fell(warnN));
endmodule // fwdr_checker

bind fault_warning_diag_regs fwdr_checker #(.TONE_DIV(TONE_DIV)) u_fwdr_checker (
   .sys_clk, .resetn, .scl, .thermalShutdownFlag, .chOneThermalShutdown,
   .chTwoThermalShutdown, .thermalWarningFlag, .chOneThermalWarning, .chTwoThermalWarning,
   .ocFault, .uvFault, .ovFault, .dcFault, .clipDetect, .faultN, .warnN, .testDriveOn,
   .testGainFour, .impedanceTestReturnPath, .toneTestDriveLevel, .testBusy
);

// ===== bench/fault_warning_diag_regs_tb.sv
`timescale 1ns/1ps
module fault_warning_diag_regs_tb;
   localparam logic [15:0] DIV = 16'h0004;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic scl, sdaIn, sdaOut, sdaOe, faultN, warnN, loopOn;
   logic [2:0] tsd = 3'h0;
   logic [2:0] tw = 3'h0;
   logic [4:0] flt = 5'h00;
   logic [7:0] smpOne = 8'h00;
   logic [7:0] smpTwo = 8'h00;
   logic [7:0] d, old;
   logic [31:0] r;
   logic [1:0] drvOn, gain4, level, busy;
   int fails = 0;
   int numChecks = 0;
   int seed = 73572;
   int pos[7] = '{7, 6, 5, 4, 3, 1, 0};
   fault_warning_diag_regs #(.TONE_DIV(DIV)) dut (
      .sys_clk, .resetn, .scl, .sdaIn, .sdaOut, .sdaOe,
      .thermalShutdownFlag(tsd[2]), .chOneThermalShutdown(tsd[1]),
      .chTwoThermalShutdown(tsd[0]), .thermalWarningFlag(tw[2]),
      .chOneThermalWarning(tw[1]), .chTwoThermalWarning(tw[0]),
      .ocFault(flt[4]), .clipDetect(flt[3]), .uvFault(flt[2]), .ovFault(flt[1]),
      .dcFault(flt[0]), .sampleChOne(smpOne), .sampleChTwo(smpTwo), .faultN, .warnN,
      .testDriveOn(drvOn), .testGainFour(gain4), .impedanceTestReturnPath(loopOn),
      .toneTestDriveLevel(level), .testBusy(busy)
   );
   fwdr_host_model host (.clk(sys_clk), .sdaOe, .scl, .sdaIn);
   function automatic logic [7:0] statusExp(input logic por, input logic [2:0] v);
      return {2'b00, por, v, 2'b00};
   endfunction
   function automatic logic [7:0] impExp(input logic [7:0] s, input logic g);
      return g ? {2'b00, s[7:2]} : s;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      numChecks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic n;
      host.wr(a, v, n);
      chk({7'h00, n}, 8'h00, "write nak");
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      logic n;
      host.rd(a, q, n);
      chk({6'h00, sdaOut, n}, 8'h00, "read nak");
      chk(q, exp, "readback");
   endtask
   // Raise or drop the condition behind one mask bit
   task automatic setSrc(input int p, input logic v);
      @(posedge sys_clk);
      case (p)
         6: tsd[2] <= v;
         1: flt[3] <= v;
         0: tw[2] <= v;
         default: flt[p - 3] <= v;
      endcase
   endtask
   task automatic waitIdle();
      int n;
      n = 0;
      while (busy !== 2'b00 && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      chk({6'h00, busy}, 8'h00, "run hung");
   endtask
   task automatic wrapUp();
      $display("checks %0d mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial forever #2 sys_clk = ~sys_clk;
   // Watchdog
   initial begin
      repeat (90000) @(posedge sys_clk);
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      wrapUp();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      // Reset values
      rdc(8'h12, 8'h00);
      rdc(8'h13, 8'h20);
      for (int i = 0; i < 6; i++) rdc(8'h14 + 8'(i), 8'h00);
      rdc(8'h21, 8'h00);
      // Status flags, read-only write, latch and clear
      r = $random(seed);
      @(posedge sys_clk);
      tsd <= r[2:0] | 3'h4;
      tw <= r[5:3];
      repeat (4) @(posedge sys_clk);
      rdc(8'h12, statusExp(1'b0, tsd));
      rdc(8'h13, statusExp(1'b1, tw));
      wr(8'h12, 8'hff);
      @(posedge sys_clk);
      old = statusExp(1'b0, tsd);
      tsd <= 3'h0;
      tw <= 3'h0;
      rdc(8'h12, old);
      wr(8'h21, 8'h80);
      rdc(8'h12, 8'h00);
      rdc(8'h13, 8'h00);
      rdc(8'h21, 8'h00);
      // Random controls, reserved current, slow host on odd passes
      for (int i = 0; i < 8; i++) begin
         host.ph = 4 + (i % 2) * 3;
         r = $random(seed);
         d = r[7:0];
         wr(8'h14, d);
         rdc(8'h14, d);
         wr(8'h15, d);
         rdc(8'h15, d);
         chk({4'h0, gain4, drvOn}, {4'h0, d[6], d[7], d[2], d[3]}, "test enables");
         old = r[15:8] & 8'hf7;
         wr(8'h16, old);
         wr(8'h16, r[23:16] | 8'h08);
         d = {r[23:20], old[3:2], r[17:16]};
         rdc(8'h16, d);
         chk({5'h00, loopOn, level}, {5'h00, d[7], d[3:2]}, "test modes");
      end
      host.ph = 4;
      wr(8'h15, 8'h00);
      // Each mask bit against its pin
      for (int k = 0; k < 7; k++) begin
         for (int m = 0; m < 2; m++) begin
            wr(8'h14, m[0] ? 8'h01 << pos[k] : 8'h00);
            setSrc(pos[k], 1'b1);
            repeat (4) @(posedge sys_clk);
            d = {7'h00, pos[k] < 2 ? warnN : faultN};
            chk(d, {7'h00, m[0]}, "pin mask");
            setSrc(pos[k], 1'b0);
            wr(8'h21, 8'h80);
            repeat (4) @(posedge sys_clk);
            chk({6'h00, faultN, warnN}, 8'h03, "pins idle");
         end
      end
      // Both channels long, then channel two short
      r = $random(seed);
      @(posedge sys_clk);
      smpOne <= r[7:0];
      smpTwo <= r[15:8];
      wr(8'h16, 8'h10);
      wr(8'h15, 8'h8c);
      chk({6'h00, busy}, 8'h03, "both runs");
      waitIdle();
      rdc(8'h17, impExp(smpOne, 1'b1));
      rdc(8'h18, impExp(smpTwo, 1'b0));
      wr(8'h15, 8'h00);
      wr(8'h16, 8'h00);
      wr(8'h15, 8'h44);
      chk({6'h00, busy}, 8'h02, "run two only");
      waitIdle();
      rdc(8'h18, impExp(smpTwo, 1'b1));
      // Foreign bus address gets no acknowledge
      host.start_cond();
      host.xfer({fwdr_pkg::BUS_ADDR ^ 7'h01, 1'b0}, 1'b1, d, r[0]);
      host.stop_cond();
      chk({7'h00, r[0]}, 8'h01, "foreign ack");
      wrapUp();
   end
endmodule // fault_warning_diag_regs_tb
